// file: verilog/sdf_pkg.sv
// Package with constants for the step and direction input front end
package sdf_pkg;
    localparam int unsigned TABLE_ENTRIES   = 1024;
    localparam int unsigned POS_W           = 10;
    localparam int unsigned RES_W           = 4;
    localparam int unsigned MAX_RES_CODE    = 8;
    localparam int unsigned CURR_W          = 8;
    localparam int unsigned SYNC_STAGES     = 2;
    localparam int unsigned FULLSTEP_DIV    = 512;
    localparam int unsigned LOW_RANGE_PCT   = 55;
    localparam int unsigned FULL_RANGE_PCT  = 100;
    localparam logic [9:0]  POS_RESET       = 10'h000;
    localparam logic [7:0]  CURR_RESET      = 8'h00;
    localparam logic [3:0]  RES_FINEST      = 4'h0;
endpackage : sdf_pkg

// file: verilog/sdf_step_if.sv
// Interface carrying synchronised step events between modules
`timescale 1ns/1ps
interface sdf_step_if;
    logic step_evt;
    logic dir;
    modport src (output step_evt, output dir);
    modport dst (input step_evt, input dir);
endinterface : sdf_step_if

// file: verilog/sdf_sync.sv
// Two stage synchroniser with rising edge step event generator
`timescale 1ns/1ps
module sdf_sync
(
    input  wire logic  clock_i,
    input  wire logic  rst_n_i,
    input  wire logic  step_pin_i,
    input  wire logic  dir_pin_i,
    sdf_step_if.src    evt
);
    logic [1:0] step_sync_r;
    logic [1:0] dir_sync_r;
    logic       step_prev_r;
    logic       evt_r;
    logic       dir_r;

    // Synchronise both pins; first stage feeds only the second
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            step_sync_r <= 2'h0;
            dir_sync_r  <= 2'h0;
        end
        else
        begin
            step_sync_r <= {step_sync_r[0], step_pin_i};
            dir_sync_r  <= {dir_sync_r[0], dir_pin_i};
        end
    end

    // Rising edge only; falling edge gives nothing
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            step_prev_r <= 1'b0;
            evt_r       <= 1'b0;
            dir_r       <= 1'b0;
        end
        else
        begin
            step_prev_r <= step_sync_r[1];
            evt_r       <= step_sync_r[1] & ~step_prev_r;
            dir_r       <= dir_sync_r[1];
        end
    end

    assign evt.step_evt = evt_r;
    assign evt.dir      = dir_r;
endmodule : sdf_sync

// file: verilog/sdf_front_end.sv
// Step and direction input front end with microstep position counter
// Function
// - Only rising edges of the advance input make a step event.
// - Advance and sense inputs are synchronised to the system clock.
// - On-resistance sensing bit selects switch current measurement.
// - Low sense range reduces peak current to about 55 percent.
// - Step adds width when sense is 0, subtracts when 1.
// - Position indexes a 1024 entry table over four fullsteps.
`timescale 1ns/1ps
module sdf_front_end
#(
    parameter int unsigned POS_W = sdf_pkg::POS_W
)
(
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    step_pin_i,
    input  wire logic                    dir_pin_i,
    input  wire logic [3:0]              res_code_i,
    input  wire logic                    cfg_rdson_sense_i,
    input  wire logic                    cfg_low_range_i,
    input  wire logic [7:0]              curr_ref_i,
    output      logic                    step_evt_o,
    output      logic                    dir_o,
    output      logic [POS_W-1:0]        position_o,
    output      logic                    use_rdson_o,
    output      logic [7:0]              curr_peak_o
);
    // Position must wrap exactly at one electrical revolution
    if ((1 << POS_W) != sdf_pkg::TABLE_ENTRIES)
        $error("POS_W must cover exactly the table size");

    // Synchronised event and sense travel together in one carrier
    sdf_step_if evt_if ();

    // Microstep position; index into the sine table downstream
    logic [POS_W-1:0] pos_r;

    // Step width decoded from the registered resolution code
    logic [POS_W-1:0] width;

    // Resolution code as seen by the position counter
    logic [3:0]       res_r;

    // Output copies of the step event and its rotation sense
    logic             evt_r;
    logic             dir_r;

    // Sense configuration, registered before it leaves the block
    logic             rdson_r;
    logic [7:0]       peak_r;

    // Scaled reference; wide enough for the product before division
    logic [15:0]      scaled;

    // Pin synchroniser and rising edge detector
    sdf_sync u_sync
    (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .step_pin_i (step_pin_i),
        .dir_pin_i  (dir_pin_i),
        .evt        (evt_if)
    );

    // Resolution code clamps to fullstep; width 1 at finest.
    // Codes above the fullstep code would overflow the table,
    // so they are held at the fullstep width instead.
    always_comb
    begin
        if (res_r > sdf_pkg::MAX_RES_CODE[3:0])
        begin
            width = POS_W'(1 << sdf_pkg::MAX_RES_CODE);
        end
        else
        begin
            width = POS_W'(1 << res_r);
        end
    end

    // Resolution register, defined after reset.
    // Registering the code only delays it by one cycle; a new code
    // still reaches the width while the synchroniser is carrying an event.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            res_r <= sdf_pkg::RES_FINEST;
        end
        else
        begin
            res_r <= res_code_i;
        end
    end

    // Position counter wraps naturally at table size.
    // The width of the counter equals log2 of the table size,
    // so no explicit modulo logic is needed in either direction.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pos_r <= sdf_pkg::POS_RESET;
        end
        else if (evt_if.step_evt)
        begin
            if (evt_if.dir)
            begin
                pos_r <= pos_r - width;
            end
            else
            begin
                pos_r <= pos_r + width;
            end
        end
    end

    // Registered step event; one cycle, aligned with the new position
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            evt_r <= 1'b0;
        end
        else
        begin
            evt_r <= evt_if.step_evt;
        end
    end

    // Registered rotation sense; same sample the counter used
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dir_r <= 1'b0;
        end
        else
        begin
            dir_r <= evt_if.dir;
        end
    end

    // Low range scales the reference; 55/100 kept as integer ratio.
    // Floor rounding is accepted: the analog side is far coarser
    // than one code of the reference.
    assign scaled = cfg_low_range_i
        ? 16'((curr_ref_i * sdf_pkg::LOW_RANGE_PCT)
              / sdf_pkg::FULL_RANGE_PCT)
        : {8'h00, curr_ref_i};

    // On-resistance sensing select; a one-time option, so only copied
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdson_r <= 1'b0;
        end
        else
        begin
            rdson_r <= cfg_rdson_sense_i;
        end
    end

    // Peak current; upper bits of the product are zero after division
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            peak_r <= sdf_pkg::CURR_RESET;
        end
        else
        begin
            peak_r <= scaled[7:0];
        end
    end

    // Step event and sense leave straight from flip-flops
    assign step_evt_o  = evt_r;
    assign dir_o       = dir_r;

    // Position leaves straight from the counter register
    assign position_o  = pos_r;

    // Sense configuration leaves straight from flip-flops
    assign use_rdson_o = rdson_r;
    assign curr_peak_o = peak_r;
endmodule : sdf_front_end

// file: tb/sdf_ctrl_model.sv
// Controller model making step pulses
`timescale 1ns/1ps
module sdf_ctrl_model
(
    input  wire logic clock_i,
    input  wire logic run_i,
    input  wire logic slow_i,
    output wire logic step_o
);
    logic [2:0] cnt_r = 3'h0;
    // Ends its period, so pulses stay 2+ cycles high and low
    always_ff @(posedge clock_i)
        if (run_i || cnt_r != 3'h0) cnt_r <= cnt_r + 3'h1;
    assign step_o = slow_i ? cnt_r[2] : cnt_r[1];
endmodule : sdf_ctrl_model

// file: tb/sdf_front_end_properties.sv
// Concurrent checks on the front end ports
`timescale 1ns/1ps
module sdf_front_end_properties
#(parameter int unsigned POS_W = 10)
(
    input wire logic clock_i, rst_n_i, step_pin_i, dir_pin_i, step_evt_o,
    input wire logic dir_o, use_rdson_o, cfg_rdson_sense_i, cfg_low_range_i,
    input wire logic [3:0] res_code_i,
    input wire logic [7:0] curr_ref_i, curr_peak_o,
    input wire logic [POS_W-1:0] position_o
);
    logic [POS_W-1:0] w;
    // Codes above 8 clamp to a fullstep
    assign w = (res_code_i > 4'h8) ? POS_W'(256) : POS_W'(1) << res_code_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_once; step_evt_o |=> !step_evt_o; endproperty
    a_once: assert property (p_once) else $error("long");
    property p_rise; $rose(step_pin_i) |-> ##[4:5] step_evt_o; endproperty
    a_rise: assert property (p_rise) else $error("lost");
    property p_fall; $fell(step_pin_i) |-> ##4 !step_evt_o [*2]; endproperty
    a_fall: assert property (p_fall) else $error("fall");
    property p_hold; $changed(position_o) |-> step_evt_o; endproperty
    a_hold: assert property (p_hold) else $error("drift");
    property p_move;
        step_evt_o |-> position_o == $past(position_o) + (dir_o ? -w : w);
    endproperty
    a_move: assert property (p_move) else $error("step");
    property p_dir; step_evt_o |-> dir_o == $past(dir_pin_i, 4); endproperty
    a_dir: assert property (p_dir) else $error("dir");
    property p_rds;
        $past(rst_n_i, 2) |-> use_rdson_o == $past(cfg_rdson_sense_i);
    endproperty
    a_rds: assert property (p_rds) else $error("rdson");
    property p_cur; $past(rst_n_i, 2) |-> curr_peak_o == ($past(cfg_low_range_i)
        ? $past(curr_ref_i) * 55 / 100 : $past(curr_ref_i)); endproperty
    a_cur: assert property (p_cur) else $error("peak");
    c_up: cover property (step_evt_o && !dir_o);
    c_dn: cover property (step_evt_o && dir_o);
    c_lo: cover property (cfg_low_range_i && curr_peak_o != 8'h00);
endmodule : sdf_front_end_properties
bind sdf_front_end sdf_front_end_properties #(.POS_W(POS_W)) u_props (.*);

// file: tb/sdf_front_end_tb.sv
// Row driven bench for the front end
`timescale 1ns/1ps
module sdf_front_end_tb;
    // Rows: dir, res, low, rdson, slow, ref, expected peak
    logic [23:0] rows [4] = '{24'h00C8C8, 24'h9FFF8C, 24'h426464, 24'hFD0A05};
    logic clock_i = 1'h0, rst_n_i = 1'h0, run = 1'h0, dr, lo, rd, sl, st, ev;
    logic       ur, dro;
    logic [3:0] res;
    logic [7:0] cr, pk, pe;
    logic [9:0] pos, wt, ep = 10'h000;
    int mismatches = 0, checked = 0, nev = 0, nris = 0;
    // Clock and independent counts of pin rises and events
    always #4 clock_i = ~clock_i;
    always @(posedge st) nris++;
    always @(posedge clock_i) nev += int'(ev === 1'h1);
    sdf_ctrl_model u_ctrl (.clock_i, .run_i(run), .slow_i(sl), .step_o(st));
    sdf_front_end uut (.clock_i, .rst_n_i, .step_pin_i(st), .dir_pin_i(dr),
        .res_code_i(res), .cfg_rdson_sense_i(rd), .cfg_low_range_i(lo),
        .curr_ref_i(cr), .step_evt_o(ev), .dir_o(dro), .position_o(pos),
        .use_rdson_o(ur), .curr_peak_o(pk));
    task automatic check(input logic [9:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t %h not %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    // Dir only moves while idle; reset held long enough for pin to fall
    initial
    begin
        {dr, res, lo, rd, sl, cr, pe} = rows[0];
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'h1;
        foreach (rows[i])
        begin
            {dr, res, lo, rd, sl, cr, pe} <= rows[i];
            repeat (8) @(posedge clock_i);
            nris = 0;
            nev = 0;
            run <= 1'h1;
            repeat (40) @(posedge clock_i);
            run <= 1'h0;
            repeat (20) @(posedge clock_i);
            wt = (res > 4'h8) ? 10'h100 : 10'h001 << res;
            ep = dr ? ep - 10'(nris) * wt : ep + 10'(nris) * wt;
            check(pos, ep);
            check(10'(nev), 10'(nris));
            check({2'h0, pk}, {2'h0, pe});
            check({9'h0, ur}, {9'h0, rd});
            check({9'h0, dro}, {9'h0, dr});
        end
        run <= 1'h1;
        repeat (5) @(posedge clock_i);
        {run, rst_n_i} <= 2'h0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'h1;
        repeat (9) @(posedge clock_i);
        check(pos, 10'h000);
        summarize();
    end
    // Run needs about 300 cycles
    initial
    begin
        repeat (2000) @(posedge clock_i);
        mismatches++;
        summarize();
    end
endmodule : sdf_front_end_tb
